/* design/ana_pkg.sv */
// constants for the auto-negotiation ability register pair
package ana_pkg;
    // ***************************************************************
    // register addresses on the management port
    // ***************************************************************
    localparam logic [4:0] ANA_ADDR_ADV = 5'h04;
    localparam logic [4:0] ANA_ADDR_LP = 5'h05;
    localparam logic [4:0] ANA_ADDR_EXP = 5'h06;
    localparam int ANA_ADDR_W = 5;
    localparam int ANA_DATA_W = 16;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int ANA_BIT_NP = 15;
    localparam int ANA_BIT_ACK = 14;
    localparam int ANA_BIT_RF = 13;
    localparam int ANA_BIT_PAUSE = 10;
    localparam int ANA_BIT_T4 = 9;
    localparam int ANA_BIT_ABIL_HI = 8;
    localparam int ANA_BIT_ABIL_LO = 5;
    localparam int ANA_SEL_HI = 4;

    // ***************************************************************
    // masks and reset values
    // ***************************************************************
    // writable bits: 15, 13, 12:11 (reserved), 10, 8:5
    localparam logic [15:0] ANA_ADV_RW_MASK = 16'hbde0;
    localparam logic [15:0] ANA_ADV_RW_RESET = 16'h0000;
    localparam logic [4:0] ANA_SELECTOR_8023 = 5'h01;
    localparam logic [15:0] ANA_LP_RESET = 16'h0001;
    localparam logic [15:0] ANA_RDATA_NONE = 16'h0000;

    // ***************************************************************
    // link pulse burst acknowledge
    // ***************************************************************
    localparam logic [1:0] ANA_ACK_BURSTS = 2'h3;
endpackage

/* design/ana_ability_regs.sv */
// advertisement and link partner ability registers of the phy
`timescale 1ns/100ps
`default_nettype none
module ana_ability_regs
    import ana_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    input wire logic [ANA_ADDR_W-1:0] i_mgmt_addr,
    input wire logic i_mgmt_wr,
    input wire logic i_mgmt_rd,
    input wire logic [ANA_DATA_W-1:0] i_mgmt_wdata,
    input wire logic [3:0] i_status_ability,
    input wire logic i_burst_valid,
    input wire logic [ANA_DATA_W-1:0] i_burst_word,
    input wire logic i_an_restart,
    input wire logic i_an_complete,
    output logic [ANA_DATA_W-1:0] o_mgmt_rdata,
    output logic o_mgmt_rvalid,
    output logic [ANA_DATA_W-1:0] o_tx_base_page,
    output logic o_page_received,
    output logic o_regs_valid
);

    // ***************************************************************
    // state
    // ***************************************************************
    logic [15:0] adv_rw_q;
    logic [15:0] adv_rw_d;
    logic ack_q;
    logic [1:0] match_cnt_q;
    logic [15:0] prev_word_q;
    logic [15:0] lp_q;
    logic page_rx_q;
    logic [15:0] rdata_q;
    logic rvalid_q;
    logic [15:0] tx_q;
    logic valid_q;
    logic burst_match;
    logic third_burst;
    logic wr_adv;
    logic rd_exp;

    // full view of the advertisement register
    function automatic logic [15:0] adv_view(input logic [15:0] rw,
                                             input logic ack);
        logic [15:0] v;
        v = rw & ANA_ADV_RW_MASK;
        v[ANA_BIT_ACK] = ack;
        v[ANA_BIT_T4] = 1'b0;
        v[ANA_SEL_HI:0] = ANA_SELECTOR_8023;
        return v;
    endfunction

    // ***************************************************************
    // decode
    // ***************************************************************
    // request strobes and burst consistency
    assign wr_adv = i_mgmt_wr && (i_mgmt_addr == ANA_ADDR_ADV);
    assign rd_exp = i_mgmt_rd && (i_mgmt_addr == ANA_ADDR_EXP);
    assign burst_match = (i_burst_word == prev_word_q) && (match_cnt_q != 2'h0);
    assign third_burst = i_burst_valid && burst_match &&
                         (match_cnt_q == ANA_ACK_BURSTS - 2'h1);

    // next value of the writable bits; read-only bits masked away
    always_comb begin
        adv_rw_d = adv_rw_q;
        if (wr_adv) begin
            adv_rw_d = (adv_rw_q & ~ANA_ADV_RW_MASK) |
                       (i_mgmt_wdata & ANA_ADV_RW_MASK);
        end
    end

    // ***************************************************************
    // advertisement register
    // ***************************************************************
    // ability bits copy the status abilities while reset is held
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            adv_rw_q <= ANA_ADV_RW_RESET;
            adv_rw_q[ANA_BIT_ABIL_HI:ANA_BIT_ABIL_LO] <=
                i_status_ability;
        end else begin
            adv_rw_q <= adv_rw_d;
        end
    end

    // count consecutive identical bursts, restart on mismatch
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || i_an_restart) begin
            match_cnt_q <= 2'h0;
            prev_word_q <= 16'h0000;
        end else if (i_burst_valid) begin
            prev_word_q <= i_burst_word;
            if (!burst_match) begin
                match_cnt_q <= 2'h1;
            end else if (match_cnt_q != ANA_ACK_BURSTS) begin
                match_cnt_q <= match_cnt_q + 2'h1;
            end
        end
    end

    // acknowledge is set by hardware only; a restart clears it and the burst counter,
    // so it beats a third burst in the same cycle here; lp_q and the page flag still load
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || i_an_restart) begin
            ack_q <= 1'b0;
        end else if (third_burst) begin
            ack_q <= 1'b1;
        end
    end

    // ***************************************************************
    // link partner register and page flag
    // ***************************************************************
    // received base page stored bit for bit
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            lp_q <= ANA_LP_RESET;
        end else if (third_burst) begin
            lp_q <= i_burst_word;
        end
    end

    // page received: a new page wins over a same-cycle read
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            page_rx_q <= 1'b0;
        end else if (third_burst) begin
            page_rx_q <= 1'b1;
        end else if (rd_exp) begin
            page_rx_q <= 1'b0;
        end
    end

    // ***************************************************************
    // management read and outputs
    // ***************************************************************
    // read data one cycle after the read strobe
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            rdata_q <= ANA_RDATA_NONE;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_mgmt_rd;
            if (!i_mgmt_rd) begin
                rdata_q <= rdata_q;
            end else if (i_mgmt_addr == ANA_ADDR_ADV) begin
                rdata_q <= adv_view(adv_rw_q, ack_q);
            end else if (i_mgmt_addr == ANA_ADDR_LP) begin
                rdata_q <= lp_q;
            end else begin
                rdata_q <= ANA_RDATA_NONE;
            end
        end
    end

    // transmitted word follows the advertisement register
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            tx_q <= adv_view(ANA_ADV_RW_RESET, 1'b0);
        end else begin
            tx_q <= adv_view(adv_rw_q, ack_q);
        end
    end

    // registers valid once negotiation has completed
    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n || i_an_restart) begin
            valid_q <= 1'b0;
        end else begin
            valid_q <= i_an_complete;
        end
    end

    assign o_mgmt_rdata = rdata_q;
    assign o_mgmt_rvalid = rvalid_q;
    assign o_tx_base_page = tx_q;
    assign o_page_received = page_rx_q;
    assign o_regs_valid = valid_q;

    // ***************************************************************
    // assertions
    // ***************************************************************
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    a_np_after_reset: assert property (
        $rose(i_reset_n) |-> !adv_rw_q[ANA_BIT_NP] && !ack_q)
        else $error("next page or ack not zero after reset");

    a_ack_three_bursts: assert property (
        (i_burst_valid && match_cnt_q == 2'h2 && burst_match
         && !i_an_restart) |=> ack_q && o_page_received)
        else $error("ack not set on third consistent burst");

    a_ack_needs_bursts: assert property (
        $rose(ack_q) |-> $past(i_burst_valid) && $past(match_cnt_q) == 2'h2)
        else $error("ack set without three bursts");

    a_rw_write_taken: assert property (
        (wr_adv && !i_mgmt_rd) ##1 (i_mgmt_rd && i_mgmt_addr == ANA_ADDR_ADV
         && !i_mgmt_wr) |=> (o_mgmt_rdata & ANA_ADV_RW_MASK) ==
         ($past(i_mgmt_wdata, 2) & ANA_ADV_RW_MASK))
        else $error("advertisement write not stored");

    a_ro_fixed: assert property (
        o_mgmt_rvalid && $past(i_mgmt_addr) == ANA_ADDR_ADV |->
        o_mgmt_rdata[ANA_SEL_HI:0] == ANA_SELECTOR_8023 &&
        !o_mgmt_rdata[ANA_BIT_T4] && o_mgmt_rdata[ANA_BIT_ACK] == $past(ack_q))
        else $error("read-only advertisement bits changed");

    a_lp_load: assert property (
        third_burst && !i_an_restart |=> lp_q == $past(i_burst_word))
        else $error("partner word not loaded");

    a_page_set_wins: assert property (
        third_burst && rd_exp |=> o_page_received)
        else $error("page flag lost to same-cycle read");

    a_page_clear_read: assert property (
        o_page_received && rd_exp && !third_burst |=> !o_page_received)
        else $error("page flag not cleared by read");

    a_tx_follows: assert property (
        ##1 1 |-> o_tx_base_page == adv_view($past(adv_rw_q), $past(ack_q)))
        else $error("tx word differs from advertisement");

    a_valid_tracks: assert property (
        i_an_complete && !i_an_restart |=> o_regs_valid)
        else $error("valid flag not following completion");

    // ***************************************************************
    // field assertions
    // ***************************************************************

    // remote fault and pause bits come out of reset cleared
    a_rf_pause_reset: assert property (
        $rose(i_reset_n) |->
        !adv_rw_q[ANA_BIT_RF] && !adv_rw_q[ANA_BIT_PAUSE])
        else $error("remote fault or pause bit set after reset");

    // ability bits leave reset with the last status value seen
    a_ability_reset: assert property (
        $rose(i_reset_n) |->
        adv_rw_q[ANA_BIT_ABIL_HI:ANA_BIT_ABIL_LO] == $past(i_status_ability))
        else $error("ability bits did not take status value at reset");

    // next-page enable follows a management write
    a_np_write: assert property (
        wr_adv |=>
        adv_rw_q[ANA_BIT_NP] == $past(i_mgmt_wdata[ANA_BIT_NP]))
        else $error("next page bit not written");

    // pause capability follows a management write
    a_pause_write: assert property (
        wr_adv |=>
        adv_rw_q[ANA_BIT_PAUSE] == $past(i_mgmt_wdata[ANA_BIT_PAUSE]))
        else $error("pause bit not written");

    // ability bits follow a management write
    a_ability_write: assert property (
        wr_adv |=> adv_rw_q[ANA_BIT_ABIL_HI:ANA_BIT_ABIL_LO] ==
        $past(i_mgmt_wdata[ANA_BIT_ABIL_HI:ANA_BIT_ABIL_LO]))
        else $error("ability bits not written");

    // bits outside the writable mask never move on a write
    a_ro_write_kept: assert property (
        wr_adv |=> (adv_rw_q & ~ANA_ADV_RW_MASK) ==
        $past(adv_rw_q & ~ANA_ADV_RW_MASK))
        else $error("read-only advertisement bits written");

    // sent word always carries t4 clear and the fixed selector
    a_tx_fixed_bits: assert property (
        !o_tx_base_page[ANA_BIT_T4] &&
        o_tx_base_page[ANA_SEL_HI:0] == ANA_SELECTOR_8023)
        else $error("fixed bits of sent word wrong");

    // partner register leaves reset with only the selector set
    a_lp_reset: assert property (
        $rose(i_reset_n) |-> lp_q == ANA_LP_RESET)
        else $error("partner register not at reset value");

    // partner register only moves on a third matching burst
    a_lp_holds: assert property (
        !third_burst |=> $stable(lp_q))
        else $error("partner register changed without a load");

    // a partner read returns the stored word unchanged
    a_lp_read: assert property (
        o_mgmt_rvalid && $past(i_mgmt_addr) == ANA_ADDR_LP |->
        o_mgmt_rdata == $past(lp_q))
        else $error("partner read data wrong");

    // page flag leaves reset cleared
    a_page_reset: assert property (
        $rose(i_reset_n) |-> !page_rx_q)
        else $error("page flag set after reset");

    // page flag only rises when a partner word is stored
    a_page_needs_word: assert property (
        $rose(o_page_received) |-> $past(third_burst))
        else $error("page flag set without a stored word");

    // restart drops the acknowledge
    a_ack_restart: assert property (
        i_an_restart |=> !ack_q)
        else $error("ack kept over restart");

    // valid flag falls once completion goes away
    a_valid_drops: assert property (
        !i_an_complete |=> !o_regs_valid)
        else $error("valid flag kept without completion");

    // main scenarios seen
    c_ack_set: cover property (third_burst);
    c_adv_write_read: cover property (wr_adv ##1 i_mgmt_rd);
    c_page_read_clear: cover property (o_page_received ##1 rd_exp);
    c_restart: cover property (ack_q ##1 i_an_restart);
    c_set_and_read: cover property (third_burst && rd_exp);

endmodule
`default_nettype wire

/* bench/ana_lp_model.sv */
// link partner model that sends base-page bursts to the block
`timescale 1ns/100ps
`default_nettype none
module ana_lp_model (
    input wire logic i_core_clk,
    input wire logic i_go,
    input wire logic [15:0] i_word,
    input wire logic [1:0] i_count,
    input wire logic i_slow,
    output logic o_burst_valid = 1'b0,
    output logic [15:0] o_burst_word = 16'h0000,
    output logic o_busy
);
    logic [1:0] left_q = 2'h0;
    logic [2:0] gap_q = 3'h0;
    logic [15:0] word_q = 16'h0000;
    // sends the bursts; between bursts the word line shows the inverse
    always @(posedge i_core_clk) begin
        o_burst_valid <= 1'b0;
        o_burst_word <= ~word_q;
        if (i_go) begin
            left_q <= i_count;
            word_q <= i_word;
            gap_q <= 3'h0;
        end else if (gap_q != 3'h0) begin
            gap_q <= gap_q - 3'h1;
        end else if (left_q != 2'h0) begin
            o_burst_valid <= 1'b1;
            o_burst_word <= word_q;
            left_q <= left_q - 2'h1;
            gap_q <= i_slow ? 3'h4 : 3'h0;
        end
    end
    assign o_busy = (left_q != 2'h0) || o_burst_valid;
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the ability register pair
`timescale 1ns/100ps
`default_nettype none
module tb;
    import ana_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0;
    logic slow = 1'b0, restart = 1'b0, done = 1'b0, bv, rv, pg, vld, busy;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000, word = 16'h0000, bw, rdata, tx, adv;
    logic [3:0] strap = 4'h0;
    logic [1:0] cnt = 2'h0;
    logic [31:0] seed = 32'h8b19, r;
    logic [15:0] exp_q[$];
    int err_total = 0, check_count = 0;
    ana_ability_regs dut (.i_core_clk(clk), .i_reset_n(rst_n),
        .i_mgmt_addr(addr), .i_mgmt_wr(wr), .i_mgmt_rd(rd),
        .i_mgmt_wdata(wdata), .i_status_ability(strap),
        .i_burst_valid(bv), .i_burst_word(bw), .i_an_restart(restart),
        .i_an_complete(done), .o_mgmt_rdata(rdata), .o_mgmt_rvalid(rv),
        .o_tx_base_page(tx), .o_page_received(pg), .o_regs_valid(vld));
    ana_lp_model lp (.i_core_clk(clk), .i_go(go), .i_word(word),
        .i_count(cnt), .i_slow(slow), .o_burst_valid(bv),
        .o_burst_word(bw), .o_busy(busy));
    // ***********************************************************
    // helpers
    // ***********************************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask
    task automatic summarize();
        if (err_total == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [4:0] a, input logic [15:0] e);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    // compares the sent word and the flags where they are settled
    task automatic look(input logic [15:0] e, input logic [1:0] f);
        @(negedge clk);
        check(tx, e);
        check({14'h0000, pg, vld}, {14'h0000, f});
        @(posedge clk);
    endtask
    task automatic bursts(input logic [15:0] w, input logic [1:0] n,
                          input logic s);
        int i;
        go <= 1'b1;
        word <= w;
        cnt <= n;
        slow <= s;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        for (i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clk);
        check({15'h0000, busy}, 16'h0000);
        @(posedge clk);
    endtask
    // ***********************************************************
    // clock, read monitor and watchdog
    // ***********************************************************
    initial forever #20 clk = ~clk;
    always @(negedge clk) begin
        if (rv === 1'b1 && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end else if (rv !== 1'b0) begin
            check({15'h0000, rv}, 16'h0000);
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        summarize();
    end
    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        int i;
        r = xs();
        strap <= r[3:0];
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        adv = {7'h00, r[3:0], 5'h01};
        rd_reg(ANA_ADDR_ADV, adv);
        rd_reg(ANA_ADDR_LP, 16'h0001);
        look(adv, 2'b00);
        for (i = 0; i < 6; i++) begin
            r = (i == 0) ? 32'hffff : xs();
            wr_reg(ANA_ADDR_ADV, r[15:0]);
            adv = (r[15:0] & 16'hbde0) | 16'h0001;
            rd_reg(ANA_ADDR_ADV, adv);
        end
        look(adv, 2'b00);
        wr_reg(ANA_ADDR_LP, 16'hffff);
        rd_reg(ANA_ADDR_LP, 16'h0001);
        rd_reg(5'h07, 16'h0000);
        r = xs();
        bursts(r[15:0], 2'h2, 1'b0);
        look(adv, 2'b00);
        r = xs();
        bursts(r[15:0], 2'h3, 1'b0);
        adv[14] = 1'b1;
        look(adv, 2'b10);
        rd_reg(ANA_ADDR_LP, r[15:0]);
        rd_reg(ANA_ADDR_ADV, adv);
        r = xs();
        bursts(r[15:0], 2'h3, 1'b1);
        rd_reg(ANA_ADDR_LP, r[15:0]);
        rd_reg(ANA_ADDR_EXP, 16'h0000);
        look(adv, 2'b00);
        restart <= 1'b1;
        @(posedge clk);
        restart <= 1'b0;
        adv[14] = 1'b0;
        rd_reg(ANA_ADDR_ADV, adv);
        done <= 1'b1;
        look(adv, 2'b00);
        look(adv, 2'b01);
        done <= 1'b0;
        // third burst lands in the same cycle as a page flag read
        r = xs();
        go <= 1'b1;
        word <= r[15:0];
        cnt <= 2'h3;
        slow <= 1'b0;
        @(posedge clk);
        go <= 1'b0;
        repeat (3) @(posedge clk);
        rd_reg(ANA_ADDR_EXP, 16'h0000);
        adv[14] = 1'b1;
        look(adv, 2'b10);
        rd_reg(ANA_ADDR_LP, r[15:0]);
        rst_n <= 1'b0;
        r = xs();
        strap <= r[3:0];
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        adv = {7'h00, r[3:0], 5'h01};
        rd_reg(ANA_ADDR_ADV, adv);
        rd_reg(ANA_ADDR_LP, 16'h0001);
        repeat (3) @(posedge clk);
        check(16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule
`default_nettype wire
